//--- rtl/reset_source_map.vh
`ifndef RESET_SOURCE_MAP_VH
`define RESET_SOURCE_MAP_VH
// status field positions, reset_status_a
`define STA_POR_BIT      0
`define STA_VMON0_BIT    1
`define STA_VMON1_BIT    2
`define STA_VMON2_BIT    3
// status field positions, reset_status_b
`define STB_INDEPENDENT_WATCHDOG_BIT     0
`define STB_SWDT_BIT     1
`define STB_SW_BIT       2
`define STB_FAULT_BIT    3
// hold times in ns
`define WDOG_HOLD_NS     400
`define VMON_STAB_NS     4000
`define SW_HOLD_NS       800
`define CLK_PERIOD_NS    40
// hold counts in cycles, rounded up
`define WDOG_HOLD_CYC    ((`WDOG_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define VMON_STAB_CYC    ((`VMON_STAB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SW_HOLD_CYC      ((`SW_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// voltage level select codes
`define VLEVEL_LOW       2'h0
`define VLEVEL_MID       2'h1
`define VLEVEL_HIGH      2'h2
`endif

//--- rtl/reset_hold_timer.v
`timescale 1ns/1ns
// holds a reset for a fixed count after its request ends
module reset_hold_timer #(
  parameter HOLD = 10
) (
  input  wire core_clk,
  input  wire srst,
  input  wire start,
  output wire active
);
  reg  [15:0] countQ;
  wire [15:0] holdValue = HOLD[15:0];

  // a request pending keeps the counter reloaded; release after HOLD idle cycles
  always @(posedge core_clk) begin
    if (srst) begin
      countQ <= 16'h0000;
    end else if (start) begin
      countQ <= holdValue;
    end else if (countQ != 16'h0000) begin
      countQ <= countQ - 16'h0001;
    end
  end

  assign active = start | (countQ != 16'h0000);
endmodule // reset_hold_timer

//--- rtl/reset_source_controller.v
`timescale 1ns/1ns
`include "reset_source_map.vh"
// Operation
// R01 - watchdog underflow gives reset or NMI
// R02 - watchdog underflow sets its status flag
// R03 - watchdog reset self-releases after short delay
// R04 - system watchdog overflow gives reset or NMI
// R05 - system watchdog overflow sets its flag
// R06 - system watchdog reset self-releases after delay
// R07 - three voltage monitors give interrupt or reset
// R08 - each threshold selectable from three levels
// R09 - monitor reset held stabilization time after recovery
// R10 - monitoring off after power-on until enabled
// R11 - monitor n reset sets its flag
// R12 - core reset request bit gives software reset
// R13 - software reset held for its hold time
// R14 - peripheral fault resets always honoured
// R15 - warm-start flag separates cold from warm
// R16 - only power-on reset clears warm-start flag
// R17 - writing one sets warm-start flag, zero ignored
// R18 - power-on sets, pin reset clears, power-on flag
// R19 - external reset pin low resets device
// R20 - software reset sets its status flag
// R21 - cause flags survive warm resets
module reset_source_controller #(
  parameter WDOG_HOLD = `WDOG_HOLD_CYC,
  parameter VMON_STAB = `VMON_STAB_CYC,
  parameter SW_HOLD   = `SW_HOLD_CYC
) (
  input  wire       core_clk,
  input  wire       srst,
  input  wire       externalResetPinN,
  input  wire       indepWatchdogUnderflow,
  input  wire       indepWatchdogNmiSel,
  input  wire       systemWatchdogOverflow,
  input  wire       systemWatchdogNmiSel,
  input  wire [2:0] voltageBelow,
  input  wire [2:0] optionMonitorEnable,
  input  wire [2:0] optionMonitorResetSel,
  input  wire [5:0] optionLevelSel,
  input  wire       optionLoad,
  input  wire       systemResetRequest,
  input  wire       faultResetRequest,
  input  wire       warmStartWrite,
  input  wire       warmStartWriteData,
  output reg        chipReset,
  output reg        nmiOut,
  output reg  [2:0] voltageInterrupt,
  output reg  [5:0] voltageLevel,
  output reg  [3:0] resetStatusA,
  output reg  [3:0] resetStatusB,
  output reg        warmStartFlag
);
  // srst is the power-on reset; the pin and the internal sources are warm resets
  reg  [2:0] monEnableQ;
  reg  [2:0] monResetSelQ;
  reg  [5:0] levelQ;
  reg  [5:0] levelD;
  reg        indepPrevQ;
  reg        sysPrevQ;
  reg  [2:0] belowPrevQ;
  reg        swPrevQ;
  wire       pinReset = ~externalResetPinN;
  // events act on the rising edge; a level held high is one event
  wire       indepEvent = indepWatchdogUnderflow & ~indepPrevQ;
  wire       sysEvent   = systemWatchdogOverflow & ~sysPrevQ;
  wire       swEvent    = systemResetRequest & ~swPrevQ;
  // a disabled monitor is masked before the edge memory and the flags
  wire [2:0] belowActive = voltageBelow & monEnableQ;
  wire [2:0] belowEvent  = belowActive & ~belowPrevQ;
  // reset-mode monitors request for as long as the supply stays low
  wire [2:0] monResetReq = belowActive & monResetSelQ;
  wire       indepReset;
  wire       sysReset;
  wire       swReset;
  wire [2:0] monReset;
  reg        chipResetD;
  reg        nmiD;
  reg  [2:0] voltageIntD;
  reg  [3:0] statusAD;
  reg  [3:0] statusBD;
  reg        warmStartD;

  // edge memories reset low, the idle level of every source, so release gives no false event
  always @(posedge core_clk) begin
    if (srst) begin
      indepPrevQ <= 1'b0;
    end else begin
      indepPrevQ <= indepWatchdogUnderflow; // R01
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      sysPrevQ <= 1'b0;
    end else begin
      sysPrevQ <= systemWatchdogOverflow; // R04
    end
  end

  // only enabled monitors are remembered, so enabling a monitor already below fires once
  always @(posedge core_clk) begin
    if (srst) begin
      belowPrevQ <= 3'h0;
    end else begin
      belowPrevQ <= belowActive; // R07
    end
  end

  // a request bit left at 1 gives one reset only; it must be cleared and set again
  always @(posedge core_clk) begin
    if (srst) begin
      swPrevQ <= 1'b0;
    end else begin
      swPrevQ <= systemResetRequest; // R12
    end
  end

  // option word is loaded by the boot path; power-on clears monitoring
  always @(posedge core_clk) begin
    if (srst) begin
      monEnableQ   <= 3'h0; // R10
      monResetSelQ <= 3'h0;
    end else if (optionLoad) begin
      monEnableQ   <= optionMonitorEnable; // R10
      monResetSelQ <= optionMonitorResetSel; // R07
    end
  end

  // unused code 3 falls back to the low level so only three levels exist
  always @* begin
    levelD = levelQ;
    if (optionLoad) begin
      case (optionLevelSel[1:0])
        `VLEVEL_MID:  levelD[1:0] = `VLEVEL_MID; // R08
        `VLEVEL_HIGH: levelD[1:0] = `VLEVEL_HIGH; // R08
        default:      levelD[1:0] = `VLEVEL_LOW; // R08
      endcase
      case (optionLevelSel[3:2])
        `VLEVEL_MID:  levelD[3:2] = `VLEVEL_MID; // R08
        `VLEVEL_HIGH: levelD[3:2] = `VLEVEL_HIGH; // R08
        default:      levelD[3:2] = `VLEVEL_LOW; // R08
      endcase
      case (optionLevelSel[5:4])
        `VLEVEL_MID:  levelD[5:4] = `VLEVEL_MID; // R08
        `VLEVEL_HIGH: levelD[5:4] = `VLEVEL_HIGH; // R08
        default:      levelD[5:4] = `VLEVEL_LOW; // R08
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      levelQ <= {`VLEVEL_LOW, `VLEVEL_LOW, `VLEVEL_LOW};
    end else begin
      levelQ <= levelD;
    end
  end

  // a timer stretches its start by HOLD cycles once the start ends
  reset_hold_timer #(.HOLD(WDOG_HOLD)) indepHold (
    .core_clk (core_clk),
    .srst     (srst),
    .start    (indepEvent & ~indepWatchdogNmiSel),
    .active   (indepReset)
  ); // R03

  reset_hold_timer #(.HOLD(WDOG_HOLD)) sysHold (
    .core_clk (core_clk),
    .srst     (srst),
    .start    (sysEvent & ~systemWatchdogNmiSel),
    .active   (sysReset)
  ); // R06

  reset_hold_timer #(.HOLD(SW_HOLD)) swHold (
    .core_clk (core_clk),
    .srst     (srst),
    .start    (swEvent),
    .active   (swReset)
  ); // R13

  // monitor resets are held while below, then for the stabilization time after recovery
  reset_hold_timer #(.HOLD(VMON_STAB)) mon0Hold (
    .core_clk (core_clk),
    .srst     (srst),
    .start    (monResetReq[0]),
    .active   (monReset[0])
  ); // R09

  reset_hold_timer #(.HOLD(VMON_STAB)) mon1Hold (
    .core_clk (core_clk),
    .srst     (srst),
    .start    (monResetReq[1]),
    .active   (monReset[1])
  ); // R09

  reset_hold_timer #(.HOLD(VMON_STAB)) mon2Hold (
    .core_clk (core_clk),
    .srst     (srst),
    .start    (monResetReq[2]),
    .active   (monReset[2])
  ); // R09

  // warm sources only drive the reset tree; chipReset never loops back to clear state
  always @* begin
    chipResetD = 1'b0;
    if (pinReset) begin
      chipResetD = 1'b1; // R19
    end
    if (indepReset) begin
      chipResetD = 1'b1; // R01
    end
    if (sysReset) begin
      chipResetD = 1'b1; // R04
    end
    if (swReset) begin
      chipResetD = 1'b1; // R12
    end
    if (|monReset) begin
      chipResetD = 1'b1; // R07
    end
    if (faultResetRequest) begin
      chipResetD = 1'b1; // R14
    end
  end

  // nmi replaces the reset of a watchdog selected for it; one pulse per cycle with an event of either watchdog
  always @* begin
    nmiD = 1'b0;
    if (indepEvent & indepWatchdogNmiSel) begin
      nmiD = 1'b1; // R01
    end
    if (sysEvent & systemWatchdogNmiSel) begin
      nmiD = 1'b1; // R04
    end
  end

  // interrupt-mode monitors pulse once per dip instead of resetting
  always @* begin
    voltageIntD = belowEvent & ~monResetSelQ; // R07
  end

  // cause flags only set; the pin clear of bit 0 never meets a set of that bit
  always @* begin
    statusAD = resetStatusA;
    if (pinReset) begin
      statusAD[`STA_POR_BIT] = 1'b0; // R18
    end
    if (monResetReq[0]) begin
      statusAD[`STA_VMON0_BIT] = 1'b1; // R11
    end
    if (monResetReq[1]) begin
      statusAD[`STA_VMON1_BIT] = 1'b1; // R11
    end
    if (monResetReq[2]) begin
      statusAD[`STA_VMON2_BIT] = 1'b1; // R11
    end
  end

  always @* begin
    statusBD = resetStatusB;
    if (indepEvent) begin
      statusBD[`STB_INDEPENDENT_WATCHDOG_BIT] = 1'b1; // R02
    end
    if (sysEvent) begin
      statusBD[`STB_SWDT_BIT] = 1'b1; // R05
    end
    if (swEvent) begin
      statusBD[`STB_SW_BIT] = 1'b1; // R20
    end
    if (faultResetRequest) begin
      statusBD[`STB_FAULT_BIT] = 1'b1; // R14
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      chipReset        <= 1'b1;
      nmiOut           <= 1'b0;
      voltageInterrupt <= 3'h0;
      voltageLevel     <= 6'h00;
      resetStatusA     <= 4'h1; // R18
      resetStatusB     <= 4'h0;
    end else begin
      chipReset        <= chipResetD;
      nmiOut           <= nmiD;
      voltageInterrupt <= voltageIntD;
      voltageLevel     <= levelQ; // R08
      resetStatusA     <= statusAD; // R11
      resetStatusB     <= statusBD; // R21
    end
  end
  // R21: warm resets never touch the flags above, save the pin reset clearing the power-on flag

  // writes of 0 leave the flag alone; only power-on clears it
  always @* begin
    warmStartD = warmStartFlag;
    if (warmStartWrite & warmStartWriteData) begin
      warmStartD = 1'b1; // R17
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      warmStartFlag <= 1'b0; // R16 R15
    end else begin
      warmStartFlag <= warmStartD;
    end
  end
endmodule // reset_source_controller

//--- bench/source_model.sv
`timescale 1ns/1ns
// watchdogs, core and comparators; outputs follow fire and dip one cycle later
module source_model(
  input  wire       core_clk,
  input  wire [2:0] fire,
  input  wire [2:0] dip,
  output reg        independent_watchdog,
  output reg        swdt,
  output reg        req,
  output reg  [2:0] below
);
  always @(posedge core_clk) begin
    {req, swdt, independent_watchdog} <= fire;
    below             <= dip;
  end
endmodule // source_model

//--- bench/reset_source_controller_checker.sv
`timescale 1ns/1ns
module reset_source_controller_checker(
  input wire       core_clk,
  input wire       srst,
  input wire       externalResetPinN,
  input wire       indepWatchdogUnderflow,
  input wire       indepWatchdogNmiSel,
  input wire       systemWatchdogOverflow,
  input wire       systemResetRequest,
  input wire       faultResetRequest,
  input wire       warmStartWrite,
  input wire       warmStartWriteData,
  input wire       chipReset,
  input wire       nmiOut,
  input wire [3:0] resetStatusA,
  input wire [3:0] resetStatusB,
  input wire       warmStartFlag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  independent_watchdog_flag_a: assert property ($rose(indepWatchdogUnderflow) |=> resetStatusB[0])
    else $error("watchdog flag missing");
  independent_watchdog_reset_a:
    assert property ($rose(indepWatchdogUnderflow) && !indepWatchdogNmiSel |=> chipReset)
    else $error("watchdog reset missing");
  independent_watchdog_nmi_a:
    assert property ($rose(indepWatchdogUnderflow) && indepWatchdogNmiSel |=> nmiOut ##1 !nmiOut)
    else $error("nmi pulse wrong");
  swdt_flag_a: assert property ($rose(systemWatchdogOverflow) |=> resetStatusB[1])
    else $error("system watchdog flag missing");
  sw_reset_a:
    assert property ($rose(systemResetRequest) |=> resetStatusB[2] && chipReset ##1 chipReset)
    else $error("software reset wrong");
  fault_reset_a: assert property (faultResetRequest |=> chipReset)
    else $error("fault reset missing");
  pin_reset_a:
    assert property (!externalResetPinN |=> chipReset && !resetStatusA[0])
    else $error("pin reset wrong");
  warm_keep_a: assert property (warmStartFlag |=> warmStartFlag)
    else $error("warm flag cleared");
  warm_set_a: assert property (warmStartWrite && warmStartWriteData |=> warmStartFlag)
    else $error("warm flag not set");
  cover property ($rose(indepWatchdogUnderflow) && indepWatchdogNmiSel);
  cover property ($rose(systemResetRequest));
  cover property (!externalResetPinN);
endmodule // reset_source_controller_checker

bind reset_source_controller reset_source_controller_checker reset_source_controller_checker_i(
  .core_clk, .srst, .externalResetPinN, .indepWatchdogUnderflow, .indepWatchdogNmiSel,
  .systemWatchdogOverflow, .systemResetRequest, .faultResetRequest, .warmStartWrite,
  .warmStartWriteData, .chipReset, .nmiOut, .resetStatusA, .resetStatusB, .warmStartFlag);

//--- bench/reset_source_controller_tb.sv
`timescale 1ns/1ns
module reset_source_controller_tb;
  reg core_clk=0, srst=1, pinN=1, iSel=0, sSel=0, ld=0, fault=0, wr=0, wd=0;
  reg  [2:0] fire=0, dip=0, monEn=3'h3, monRs=3'h1;
  reg  [5:0] lvl=6'h24;
  wire [2:0] below, vInt;
  wire [5:0] vLevel;
  wire [3:0] stA, stB;
  wire       independent_watchdog, swdt, req, chipReset, nmiOut, warm;
  integer    failures=0, n_tests=0, n;
  source_model source_model_i(.core_clk(core_clk), .fire(fire), .dip(dip), .independent_watchdog(independent_watchdog),
    .swdt(swdt), .req(req), .below(below));
  // short holds keep the run brief; widths below follow from them
  reset_source_controller #(.WDOG_HOLD(3), .VMON_STAB(4), .SW_HOLD(5)) reset_source_controller_i(
    .core_clk(core_clk), .srst(srst), .externalResetPinN(pinN), .indepWatchdogUnderflow(independent_watchdog),
    .indepWatchdogNmiSel(iSel), .systemWatchdogOverflow(swdt), .systemWatchdogNmiSel(sSel),
    .voltageBelow(below), .optionMonitorEnable(monEn), .optionMonitorResetSel(monRs),
    .optionLevelSel(lvl), .optionLoad(ld), .systemResetRequest(req),
    .faultResetRequest(fault), .warmStartWrite(wr), .warmStartWriteData(wd),
    .chipReset(chipReset), .nmiOut(nmiOut), .voltageInterrupt(vInt), .voltageLevel(vLevel),
    .resetStatusA(stA), .resetStatusB(stB), .warmStartFlag(warm));
  initial forever #20 core_clk = ~core_clk;
  task chk(input [7:0] s, input [7:0] e); begin
    n_tests = n_tests + 1;
    if (s !== e) begin
      failures = failures + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  end endtask
  task tick(input integer c); begin
    repeat (c) begin
      @(posedge core_clk);
      #1;
    end
  end endtask
  // counts every reset cycle in a fixed window, so a stuck reset shows
  task width(input [7:0] e); begin
    n = 0;
    repeat (30) begin
      tick(1);
      if (chipReset === 1'b1) n = n + 1;
    end
    chk(n[7:0], e);
  end endtask
  task fireOne(input [2:0] f); begin
    fire = f;
    tick(1);
    fire = 0;
  end endtask
  task results; begin
    $display("tests=%0d failures=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end endtask
  initial begin
    #40000;
    failures = failures + 1;
    results;
  end
  initial begin
    tick(20); srst = 0; tick(2);
    chk(chipReset, 0); chk(stA, 1); chk(stB, 0); chk(warm, 0);
    fireOne(1); width(4); chk(stB, 1);
    iSel = 1; fireOne(1); tick(1); chk(nmiOut, 1); chk(chipReset, 0); iSel = 0;
    fireOne(2); width(4); chk(stB, 3);
    sSel = 1; fireOne(2); tick(1); chk(nmiOut, 1); chk(chipReset, 0); sSel = 0;
    fireOne(4); width(6); chk(stB, 7);
    fault = 1; tick(2); chk(chipReset, 1); fault = 0; tick(2); chk(stB, 8'hF);
    $display("source test done");
    dip = 1; tick(4); chk(chipReset, 0); dip = 0; tick(2);
    ld = 1; tick(1); ld = 0; tick(1); chk(vLevel, 6'h24);
    dip = 1; tick(4); chk(chipReset, 1); chk(stA, 3); dip = 0;
    tick(5); chk(chipReset, 1); tick(1); chk(chipReset, 0);
    dip = 2; tick(2); chk(vInt, 2); chk(chipReset, 0); dip = 0;
    dip = 4; tick(2); chk(vInt, 0); chk(chipReset, 0); chk(stA, 3); dip = 0;
    lvl = 6'h37; ld = 1; tick(1); ld = 0; tick(1); chk(vLevel, 6'h04);
    $display("monitor test done");
    wr = 1; tick(1); wr = 0; chk(warm, 0);
    wd = 1; wr = 1; tick(1); wr = 0; wd = 0; chk(warm, 1);
    pinN = 0; tick(2); chk(chipReset, 1); chk(stA, 2); pinN = 1; tick(2);
    chk(warm, 1); chk(stB, 8'hF);
    srst = 1; tick(2); srst = 0; tick(1); chk(warm, 0); chk(stA, 1); chk(stB, 0);
    $display("warm test done");
    results;
  end
endmodule // reset_source_controller_tb
